// File: hw/sfc_device.sv
// Device end: receives frames, checks CRC-8, commits registers, reports faults
//
// Summary of operation
// - Controller computes CRC-8 with x^8+x^2+x+1.
// - Controller appends check byte, 24 bits, then raises strobe.
// - Device checks 24-bit frame at strobe rise.
// - Good check commits data to addressed register.
// - Bad check pulls alarm low, sets D3.
// - Status read clears error flag, releases alarm.
// - Link uses clock, data and frame strobe.
// - Plain commands are 16 bits, sampled falling edge.
// - Status reports error D3, temp D2, open D1, short D0.
// - Alarm is open-drain, active low.
`timescale 1ns/100ps
`include "sfc_cfg.svh"
module sfc_device (
    input  wire logic                    sys_clk_in,
    input  wire logic                    rst_n_in,
    sfc_link_if.device                   link,
    input  wire logic                    over_temp_in,
    input  wire logic                    iout_open_in,
    input  wire logic                    vout_short_in,
    output logic                         wr_stb_out,
    output logic [`SFC_ADDR_W-1:0]       wr_addr_out,
    output logic [`SFC_DATA_W-1:0]       wr_data_out,
    output logic                         crc_err_out,
    output logic [15:0]                  status_word_out,
    output logic                         status_rd_out
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] sclk_sy;
    logic [1:0] sdat_sy;
    logic [1:0] sync_sy;
    logic       sclk_d;
    logic       sync_d;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sclk_sy <= 2'h3;
            sdat_sy <= 2'h0;
            sync_sy <= 2'h3;
            sclk_d  <= 1'b1;
            sync_d  <= 1'b1;
        end else begin
            sclk_sy <= {sclk_sy[0], link.sclk};
            sdat_sy <= {sdat_sy[0], link.sdata};
            sync_sy <= {sync_sy[0], link.sync};
            sclk_d  <= sclk_sy[1];
            sync_d  <= sync_sy[1];
        end
    end

    wire sclk_fall = sclk_d & ~sclk_sy[1];
    wire sync_rise = ~sync_d & sync_sy[1];
    wire framing   = ~sync_sy[1];
    wire take_bit  = framing & sclk_fall;

    // ----------------------------------------------------------------
    // Receive shifter and running CRC
    // ----------------------------------------------------------------
    logic [23:0]           shreg;
    logic [`SFC_CNT_W-1:0] cnt;
    sfc_pkg::sfc_crc_t     crc;
    logic                  err_flag;

    wire        is_frame  = (cnt == `SFC_CNT_FRAME);
    wire        is_cmd    = (cnt == `SFC_CNT_CMD);
    wire [15:0] word      = is_frame ? shreg[23:8] : shreg[15:0];
    wire        crc_ok    = (crc == shreg[7:0]);
    wire        good      = sync_rise & ((is_frame & crc_ok) | is_cmd);
    wire        bad       = sync_rise & is_frame & ~crc_ok;
    wire [2:0]  addr      = word[`SFC_ADDR_MSB:`SFC_ADDR_LSB];
    wire        stat_read = good & (addr == `SFC_STAT_ADDR);
    wire [15:0] stat_val  = {12'h000, err_flag, over_temp_in, iout_open_in, vout_short_in};

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shreg <= 24'h000000;
            cnt   <= `SFC_CNT_ZERO;
            crc   <= `SFC_CRC_INIT;
        end else if (!framing) begin
            cnt <= `SFC_CNT_ZERO;
            crc <= `SFC_CRC_INIT;
        end else if (take_bit) begin
            shreg <= {shreg[22:0], sdat_sy[1]};
            if (cnt != 5'h1F) begin
                cnt <= cnt + 5'h01;
            end
            // CRC covers only the first 16 bits of the frame
            if (cnt < `SFC_CNT_CMD) begin
                crc <= sfc_pkg::sfc_crc_step(crc, sdat_sy[1]);
            end
        end
    end

    // ----------------------------------------------------------------
    // Commit, status and alarm
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_stb_out      <= 1'b0;
            wr_addr_out     <= 3'h0;
            wr_data_out     <= 13'h0000;
            err_flag        <= 1'b0;
            crc_err_out     <= 1'b0;
            status_word_out <= 16'h0000;
            status_rd_out   <= 1'b0;
            link.fault_oe   <= 1'b0;
        end else begin
            // Mismatch leaves the addressed register untouched
            wr_stb_out    <= good & ~stat_read;
            status_rd_out <= stat_read;
            if (good & ~stat_read) begin
                wr_addr_out <= addr;
                wr_data_out <= word[`SFC_DATA_MSB:`SFC_DATA_LSB];
            end
            if (stat_read) begin
                status_word_out <= stat_val;
            end
            // Set wins: a read is a good frame, a fault a bad one, so
            // both never land in one cycle
            if (bad) begin
                err_flag      <= 1'b1;
                crc_err_out   <= 1'b1;
                link.fault_oe <= 1'b1;
            end else if (stat_read) begin
                err_flag      <= 1'b0;
                crc_err_out   <= 1'b0;
                link.fault_oe <= 1'b0;
            end
        end
    end
endmodule // sfc_device

// File: hw/sfc_cfg.svh
// Timing, framing and field constants for the serial frame CRC check link
`ifndef SFC_CFG_SVH
`define SFC_CFG_SVH

`define SFC_CMD_BITS        16
`define SFC_FRAME_BITS      24
`define SFC_CRC_BITS        8
`define SFC_CRC_POLY        8'h07
`define SFC_CRC_INIT        8'h00
`define SFC_CNT_W           5
`define SFC_CNT_ZERO        5'h00
`define SFC_CNT_CMD         5'h10
`define SFC_CNT_FRAME       5'h18
`define SFC_ADDR_MSB        15
`define SFC_ADDR_LSB        13
`define SFC_DATA_MSB        12
`define SFC_DATA_LSB        0
`define SFC_ADDR_W          3
`define SFC_DATA_W          13
`define SFC_STAT_ERR_BIT    3
`define SFC_STAT_OT_BIT     2
`define SFC_STAT_IOC_BIT    1
`define SFC_STAT_VSC_BIT    0
`define SFC_STAT_ADDR       3'h7
`define SFC_DIV_HALF        4'hF
`define SFC_DIV_W           4
`define SFC_DIV_ZERO        4'h0

`endif

// File: hw/sfc_pkg.sv
// Types shared by both ends of the serial frame CRC check link
package sfc_pkg;
    typedef logic [15:0] sfc_cmd_t;
    typedef logic [7:0]  sfc_crc_t;

    typedef enum logic [2:0] {
        SFC_IDLE  = 3'h1,
        SFC_SHIFT = 3'h2,
        SFC_END   = 3'h4
    } sfc_host_state_t;

    // CRC-8, x^8+x^2+x+1, one bit, MSB first
    function automatic sfc_crc_t sfc_crc_step(input sfc_crc_t crc, input logic bit_in);
        logic fb;
        fb = crc[7] ^ bit_in;
        sfc_crc_step = {crc[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
    endfunction
endpackage

// File: hw/sfc_link_if.sv
// Three-wire serial link with open-drain fault line between controller and device
`timescale 1ns/100ps
interface sfc_link_if;
    logic sclk;
    logic sdata;
    logic sync;
    logic fault_oe;
    logic fault_n;

    // Open-drain pull-up modelled as a resolved level
    assign fault_n = ~fault_oe;

    modport host (
        output sclk,
        output sdata,
        output sync,
        input  fault_n
    );
    modport device (
        input  sclk,
        input  sdata,
        input  sync,
        output fault_oe
    );
endinterface // sfc_link_if

// File: hw/sfc_host.sv
// Controller end: shifts 16-bit commands or 24-bit CRC frames to the device
`timescale 1ns/100ps
`include "sfc_cfg.svh"
module sfc_host (
    input  wire logic                sys_clk_in,
    input  wire logic                rst_n_in,
    sfc_link_if.host                 link,
    input  wire logic                req_in,
    input  wire logic                crc_en_in,
    input  wire logic [15:0]         cmd_in,
    output logic                     busy_out,
    output logic                     done_out,
    output logic                     fault_n_out
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    sfc_pkg::sfc_host_state_t state;
    logic [`SFC_DIV_W-1:0]    div;
    logic [23:0]              shreg;
    logic [`SFC_CNT_W-1:0]    left;
    logic                     sclk;
    logic                     sync;
    logic                     fault_m;
    logic                     fault_s;
    sfc_pkg::sfc_crc_t        crc;
    integer                   i;

    wire div_tick = (div == `SFC_DIV_ZERO);

    // CRC over the 16 command bits, MSB first from zero
    always_comb begin
        crc = `SFC_CRC_INIT;
        for (i = `SFC_CMD_BITS - 1; i >= 0; i = i - 1) begin
            crc = sfc_pkg::sfc_crc_step(crc, cmd_in[i]);
        end
    end

    assign link.sclk  = sclk;
    assign link.sync  = sync;
    assign link.sdata = shreg[23];

    // ----------------------------------------------------------------
    // Shifter: data changes on rising SCLK, valid at the falling edge
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state    <= sfc_pkg::SFC_IDLE;
            div      <= `SFC_DIV_HALF;
            shreg    <= 24'h000000;
            left     <= `SFC_CNT_ZERO;
            sclk     <= 1'b1;
            sync     <= 1'b1;
            done_out <= 1'b0;
            busy_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            div      <= div_tick ? `SFC_DIV_HALF : div - 4'h1;
            case (state)
                sfc_pkg::SFC_IDLE: begin
                    if (req_in) begin
                        shreg <= crc_en_in ? {cmd_in, crc} : {cmd_in, 8'h00};
                        left  <= crc_en_in ? `SFC_CNT_FRAME : `SFC_CNT_CMD;
                        sync  <= 1'b0;
                        div      <= `SFC_DIV_HALF;
                        busy_out <= 1'b1;
                        state    <= sfc_pkg::SFC_SHIFT;
                    end
                end
                sfc_pkg::SFC_SHIFT: begin
                    if (div_tick) begin
                        sclk <= ~sclk;
                        if (!sclk) begin
                            // Rising edge: next bit presented
                            shreg <= {shreg[22:0], 1'b0};
                            left  <= left - 5'h01;
                            if (left == 5'h01) begin
                                state <= sfc_pkg::SFC_END;
                            end
                        end
                    end
                end
                sfc_pkg::SFC_END: begin
                    if (div_tick) begin
                        sync     <= 1'b1;
                        done_out <= 1'b1;
                        busy_out <= 1'b0;
                        state    <= sfc_pkg::SFC_IDLE;
                    end
                end
                default: state <= sfc_pkg::SFC_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Fault line synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fault_m     <= 1'b1;
            fault_s     <= 1'b1;
            fault_n_out <= 1'b1;
        end else begin
            fault_m     <= link.fault_n;
            fault_s     <= fault_m;
            fault_n_out <= fault_s;
        end
    end
endmodule // sfc_host

// File: tb/sfc_link_properties.sv
// Concurrent checks on the serial link wires between controller and device
`timescale 1ns/100ps
module sfc_link_properties (
    input  wire logic sys_clk_in,
    input  wire logic rst_n_in,
    input  wire logic sclk,
    input  wire logic sdata,
    input  wire logic sync,
    input  wire logic fault_oe,
    input  wire logic fault_n
);
    logic [4:0] fall_cnt;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // Falling serial edges seen in the current frame
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fall_cnt <= 5'h00;
        end else if (sync) begin
            fall_cnt <= 5'h00;
        end else if ($fell(sclk)) begin
            fall_cnt <= fall_cnt + 5'h01;
        end
    end

    a_frame_starts_high: assert property ($fell(sync) |-> sclk)
        else $error("frame began with serial clock low");
    a_data_stable_fall: assert property ($fell(sclk) |-> $stable(sdata))
        else $error("data moved at sampling edge");
    a_sclk_half_period: assert property (($changed(sclk) && !sync) |=> $stable(sclk) [*8])
        else $error("serial clock half period too short");
    a_frame_length: assert property ($rose(sync) |-> (fall_cnt == 5'h10 || fall_cnt == 5'h18))
        else $error("frame not 16 or 24 bits");
    a_frame_max_bits: assert property (!sync |-> fall_cnt <= 5'h18)
        else $error("frame longer than 24 bits");
    a_fault_quiet_frame: assert property ((!sync && !$past(sync, 5)) |-> $stable(fault_oe))
        else $error("alarm moved inside a frame");
    a_fault_after_frame: assert property ($rose(fault_oe) |-> sync)
        else $error("alarm raised while strobe low");
    a_fault_line_low: assert property (fault_n == !fault_oe)
        else $error("alarm line level wrong");
endmodule // sfc_link_properties

// File: tb/serial_frame_crc8_check_test.sv
// Self-checking bench for the serial frame CRC check link, both ends
`timescale 1ns/100ps
`include "sfc_cfg.svh"
module serial_frame_crc8_check_test;
    logic                   clk = 1'b0;
    logic                   rst_n = 1'b0;
    logic                   req = 1'b0;
    logic                   crc_en = 1'b0;
    logic [15:0]            cmd = 16'h0000;
    logic [2:0]             flt = 3'h0;
    logic                   busy, done, fault_n_h, stb_a, stb_b, err_a, err_b, rd_a, rd_b;
    logic [`SFC_ADDR_W-1:0] addr_a, addr_b;
    logic [`SFC_DATA_W-1:0] data_a, data_b;
    logic [15:0]            st_a, st_b, stw_a, stw_b;
    logic [23:0]            cap = 24'h000000;
    int                     err_count = 0, num_checks = 0, cyc = 0, wr_a = 0, wr_b = 0;

    sfc_link_if link ();
    sfc_link_if link_b ();
    sfc_host sfc_host_inst (.sys_clk_in(clk), .rst_n_in(rst_n), .link(link.host), .req_in(req),
        .crc_en_in(crc_en), .cmd_in(cmd), .busy_out(busy), .done_out(done),
        .fault_n_out(fault_n_h));
    sfc_device sfc_device_inst (.sys_clk_in(clk), .rst_n_in(rst_n), .link(link.device),
        .over_temp_in(flt[2]), .iout_open_in(flt[1]), .vout_short_in(flt[0]),
        .wr_stb_out(stb_a), .wr_addr_out(addr_a), .wr_data_out(data_a), .crc_err_out(err_a),
        .status_word_out(stw_a), .status_rd_out(rd_a));
    // Second end faces a bench driver that can send corrupt frames
    sfc_device sfc_device_b_inst (.sys_clk_in(clk), .rst_n_in(rst_n), .link(link_b.device),
        .over_temp_in(flt[2]), .iout_open_in(flt[1]), .vout_short_in(flt[0]),
        .wr_stb_out(stb_b), .wr_addr_out(addr_b), .wr_data_out(data_b), .crc_err_out(err_b),
        .status_word_out(stw_b), .status_rd_out(rd_b));
    sfc_link_properties sfc_link_properties_inst (.sys_clk_in(clk), .rst_n_in(rst_n),
        .sclk(link.sclk), .sdata(link.sdata), .sync(link.sync), .fault_oe(link.fault_oe),
        .fault_n(link.fault_n));

    always #2.5 clk = ~clk;

    // ------------------------------------------------------------
    // Monitors and timeout
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cyc++;
        if (stb_a === 1'b1) wr_a++;
        if (stb_b === 1'b1) wr_b++;
        if (rd_a === 1'b1) st_a = stw_a;
        if (rd_b === 1'b1) st_b = stw_b;
        if (cyc == 40000) begin
            err_count++;
            finish_test();
        end
    end
    always @(negedge link.sclk) if (link.sync === 1'b0) cap = {cap[22:0], link.sdata};

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] crc8(input logic [15:0] c);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 15; i >= 0; i--) r = {r[6:0], 1'b0} ^ ((r[7] ^ c[i]) ? 8'h07 : 8'h00);
        return r;
    endfunction
    task check(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task send(input logic en, input logic [15:0] c);
        int n;
        @(negedge clk);
        cap = 24'h000000;
        crc_en = en;
        cmd = c;
        req = 1'b1;
        @(negedge clk);
        req = 1'b0;
        check(busy, 1'b1);
        n = 0;
        while (done !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        check(busy, 1'b0);
        repeat (8) @(negedge clk);
    endtask
    // Bench-made link clock, 64 ns, stands high between frames
    task drive_b(input logic [23:0] f);
        link_b.sync = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            link_b.sdata = f[i];
            #32 link_b.sclk = 1'b0;
            #32 link_b.sclk = 1'b1;
        end
        #32 link_b.sync = 1'b1;
        link_b.sdata = ~f[0];
        repeat (10) @(negedge clk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_plain;
        int w0;
        w0 = wr_a;
        send(1'b0, {3'h2, 13'h1555});
        check(cap, {8'h00, 3'h2, 13'h1555});
        check(24'(wr_a - w0), 24'h000001);
        check({addr_a, data_a}, {3'h2, 13'h1555});
    endtask
    task t_crc;
        int w0;
        w0 = wr_a;
        send(1'b1, {3'h5, 13'h0AAA});
        check(cap, {3'h5, 13'h0AAA, crc8({3'h5, 13'h0AAA})});
        check(24'(wr_a - w0), 24'h000001);
        check({addr_a, data_a}, {3'h5, 13'h0AAA});
        check(err_a, 1'b0);
    endtask
    task t_status;
        flt = 3'h5;
        send(1'b1, 16'hE000);
        check(st_a[3:0], 4'h5);
        check(fault_n_h, 1'b1);
    endtask
    task t_bad;
        int w0;
        w0 = wr_b;
        drive_b({16'h4321, ~crc8(16'h4321)});
        check(24'(wr_b - w0), 24'h000000);
        check(err_b, 1'b1);
        check(link_b.fault_n, 1'b0);
        drive_b({16'hE000, crc8(16'hE000)});
        check(st_b[3:0], 4'hD);
        check({err_b, link_b.fault_n}, 2'h1);
        w0 = wr_b;
        drive_b({16'h2ABC, crc8(16'h2ABC)});
        check(24'(wr_b - w0), 24'h000001);
        check({addr_b, data_b}, 16'h2ABC);
    endtask

    task finish_test;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        link_b.sclk = 1'b1;
        link_b.sdata = 1'b0;
        link_b.sync = 1'b1;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        t_plain();
        t_crc();
        t_status();
        t_bad();
        finish_test();
    end
endmodule // serial_frame_crc8_check_test
